// File: design/apcg_pkg.sv
// Package: register map, field positions and reset values of the analog clock gate
package apcg_pkg;
  localparam logic [3:0] APCG_ADDR_W        = 4'h4;
  localparam logic [3:0] APCG_GATE_OFFSET   = 4'h0;
  localparam logic [3:0] APCG_STATUS_OFFSET = 4'h4;
  localparam logic [7:0] APCG_GATE_RESET    = 8'h00;
  localparam logic [7:0] APCG_GATE_MASK     = 8'h0f;
  localparam int         APCG_CONV_BIT      = 0;
  localparam int         APCG_CMP1_BIT      = 1;
  localparam int         APCG_CMP2_BIT      = 2;
  localparam int         APCG_CTMU_BIT      = 3;
  localparam int         APCG_NUM_GATES     = 4;
  localparam logic [1:0] APCG_RESP_OKAY     = 2'b00;
  localparam logic [1:0] APCG_RESP_SLVERR   = 2'b10;
endpackage : apcg_pkg

// File: design/apcg_gate_if.sv
// Interface: per-peripheral clock and power gate controls
`timescale 1ns/1ps
interface apcg_gate_if;
  import apcg_pkg::*;
  logic [APCG_NUM_GATES-1:0] gate;
  logic [APCG_NUM_GATES-1:0] clk_en;
  logic [APCG_NUM_GATES-1:0] pwr_en;
  logic [APCG_NUM_GATES-1:0] regs_rst;
  logic [APCG_NUM_GATES-1:0] regs_access_en;
  modport ctrl (output gate, input clk_en, pwr_en, regs_rst, regs_access_en);
  modport slice (input gate, output clk_en, pwr_en, regs_rst, regs_access_en);
endinterface : apcg_gate_if

// File: design/apcg_gate_slices.sv
// Per-peripheral gate slices: clock and power enables, register reset on ungate
`timescale 1ns/1ps
module apcg_gate_slices (
  input  wire logic clock,
  input  wire logic srst,
  apcg_gate_if.slice gif
);
  import apcg_pkg::*;

  logic [APCG_NUM_GATES-1:0] gate_d_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      gate_d_reg <= APCG_GATE_RESET[APCG_NUM_GATES-1:0];
    end else begin
      gate_d_reg <= gif.gate;
    end
  end

  genvar i;
  generate
    for (i = 0; i < APCG_NUM_GATES; i++) begin : g_slice
      assign gif.clk_en[i]         = ~gif.gate[i]; // RULE1 RULE2
      assign gif.pwr_en[i]         = ~gif.gate[i]; // RULE1 RULE2
      // Hold peripheral registers inert while unpowered
      assign gif.regs_access_en[i] = ~gif.gate[i]; // RULE6
      // One-cycle reset pulse on the falling edge of a gate bit
      assign gif.regs_rst[i]       = gate_d_reg[i] & ~gif.gate[i]; // RULE7
    end
  endgenerate

  // Reset clears gates with no pulse; skip the edge right after it
  a_ungate_rst_pulse: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) && $fell(gif.gate[0]) |-> gif.regs_rst[0] ##1 !gif.regs_rst[0])
    else $error("no reset pulse on converter ungate"); // RULE7
  a_gated_no_clock: assert property (@(posedge clock) disable iff (srst)
    gif.gate[3] |-> !gif.clk_en[3] && !gif.pwr_en[3] && !gif.regs_access_en[3])
    else $error("charge timer clocked while gated"); // RULE1
endmodule : apcg_gate_slices

// File: design/apcg_top.sv
// Top: AXI4-Lite gate register controlling analog peripheral clocks and power
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Set bit cuts that peripheral clock, power
// [RULE2] Clear bit keeps peripheral clocked and powered
// [RULE3] Bit three gates charge timer unit
// [RULE4] Bit two gates comparator two
// [RULE5] Bit one gates comparator one
// [RULE6] Gated peripheral ignores writes, reads invalid
// [RULE7] Ungating resets peripheral registers to defaults
// [RULE8] Upper four bits read zero, ignore writes
module apcg_top
  import apcg_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic [APCG_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [APCG_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [APCG_NUM_GATES-1:0]       periph_clk_en,
  output logic [APCG_NUM_GATES-1:0]       periph_pwr_en,
  output logic [APCG_NUM_GATES-1:0]       periph_regs_rst,
  output logic [APCG_NUM_GATES-1:0]       periph_access_en
);
  import apcg_pkg::*;

  logic [7:0]             gate_reg;
  logic [APCG_ADDR_W-1:0] awaddr_reg;
  logic                   aw_held_reg;
  logic [31:0]            wdata_reg;
  logic                   wstrb0_reg;
  logic                   w_held_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  logic                   wr_fire;
  logic                   rd_fire;

  apcg_gate_if gif ();

  // Write channels taken independently, response after both
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign wr_fire       = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= APCG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (awaddr_reg == APCG_GATE_OFFSET || awaddr_reg == APCG_STATUS_OFFSET)
                    ? APCG_RESP_OKAY : APCG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Only the low byte lane holds implemented bits
  always_ff @(posedge clock) begin
    if (srst) begin
      gate_reg <= APCG_GATE_RESET;
    end else if (wr_fire && awaddr_reg == APCG_GATE_OFFSET && wstrb0_reg) begin
      gate_reg <= wdata_reg[7:0] & APCG_GATE_MASK; // RULE8
    end
  end

  assign gif.gate = gate_reg[APCG_NUM_GATES-1:0]; // RULE3 RULE4 RULE5

  apcg_gate_slices u_slices (
    .clock (clock),
    .srst  (srst),
    .gif   (gif)
  );

  assign periph_clk_en    = gif.clk_en;
  assign periph_pwr_en    = gif.pwr_en;
  assign periph_regs_rst  = gif.regs_rst;
  assign periph_access_en = gif.regs_access_en;

  // Read channel: one outstanding read, data registered
  assign s_axi_arready = ~rvalid_reg;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= APCG_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= APCG_RESP_OKAY;
      unique case (s_axi_araddr)
        APCG_GATE_OFFSET:   rdata_reg <= {24'h000000, gate_reg & APCG_GATE_MASK}; // RULE8
        APCG_STATUS_OFFSET: rdata_reg <= {24'h000000, 4'h0, gif.clk_en};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= APCG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  a_conv_gate_off: assert property (@(posedge clock) disable iff (srst)
    gate_reg[APCG_CONV_BIT] |-> !periph_clk_en[APCG_CONV_BIT] && !periph_pwr_en[APCG_CONV_BIT])
    else $error("converter clock on while gated"); // RULE1
  a_clear_keeps_on: assert property (@(posedge clock) disable iff (srst)
    !gate_reg[APCG_CMP1_BIT] |-> periph_clk_en[APCG_CMP1_BIT] && periph_pwr_en[APCG_CMP1_BIT])
    else $error("comparator one off while ungated"); // RULE2
  a_ctmu_bit_pos: assert property (@(posedge clock) disable iff (srst)
    wr_fire && awaddr_reg == APCG_GATE_OFFSET && wstrb0_reg
    |=> periph_clk_en[APCG_CTMU_BIT] == !$past(wdata_reg[3]))
    else $error("charge timer gate not at bit three"); // RULE3
  a_cmp2_bit_pos: assert property (@(posedge clock) disable iff (srst)
    wr_fire && awaddr_reg == APCG_GATE_OFFSET && wstrb0_reg
    |=> periph_pwr_en[APCG_CMP2_BIT] == !$past(wdata_reg[2]))
    else $error("comparator two gate not at bit two"); // RULE4
  a_cmp1_bit_pos: assert property (@(posedge clock) disable iff (srst)
    wr_fire && awaddr_reg == APCG_GATE_OFFSET && wstrb0_reg
    |=> periph_clk_en[APCG_CMP1_BIT] == !$past(wdata_reg[1]))
    else $error("comparator one gate not at bit one"); // RULE5
  a_gated_access_off: assert property (@(posedge clock) disable iff (srst)
    $rose(gate_reg[APCG_CMP2_BIT]) |-> !periph_access_en[APCG_CMP2_BIT] [*2])
    else $error("gated comparator two still accessible"); // RULE6
  // Reset clears gates with no pulse; skip the edge right after it
  a_ungate_resets: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) && $fell(gate_reg[APCG_CTMU_BIT])
    |-> periph_regs_rst[APCG_CTMU_BIT] ##1 !periph_regs_rst[APCG_CTMU_BIT])
    else $error("charge timer not reset on ungate"); // RULE7
  a_upper_zero: assert property (@(posedge clock) disable iff (srst)
    gate_reg[7:4] == 4'h0)
    else $error("unimplemented gate bits set"); // RULE8
  a_resp_after_both: assert property (@(posedge clock) disable iff (srst)
    wr_fire |=> s_axi_bvalid)
    else $error("write response late");

  c_gate_all: cover property (@(posedge clock) disable iff (srst) gate_reg == APCG_GATE_MASK);
  c_ungate: cover property (@(posedge clock) disable iff (srst) |periph_regs_rst);
  c_read_gate: cover property (@(posedge clock) disable iff (srst)
    rd_fire && s_axi_araddr == APCG_GATE_OFFSET);
  c_bad_addr: cover property (@(posedge clock) disable iff (srst)
    s_axi_rvalid && s_axi_rresp == APCG_RESP_SLVERR);
endmodule : apcg_top

// File: tb/tb_top.sv
// Testbench: register-level tests of the analog clock gate over AXI4-Lite
`timescale 1ns/1ps
module tb_top;
  import apcg_pkg::*;
  logic                  clock, srst;
  logic [APCG_ADDR_W-1:0] awaddr, araddr;
  logic                  awvalid, wvalid, bready, arvalid, rready;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [31:0]           wdata, rdata, rd_v;
  logic [3:0]            wstrb, clk_en, pwr_en, regs_rst, acc_en, rst_seen, b;
  logic [1:0]            bresp, rresp, resp;
  int                    errors, check_count, cyc;

  apcg_top dut (.clock(clock), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_clk_en(clk_en), .periph_pwr_en(pwr_en), .periph_regs_rst(regs_rst),
    .periph_access_en(acc_en));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Sticky record of reset pulses, cleared by the test before each ungate
  always @(posedge clock) begin
    rst_seen = rst_seen | regs_rst;
  end

  // About 33 transfers of a few cycles each; far below this ceiling
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task results;
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    srst = 1'b1; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    rst_seen = 4'h0; errors = 0; check_count = 0; cyc = 0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(4'h0);
    chk("gate reset", rd_v, 32'h0000_0000);
    chk("clk_en reset", clk_en, 4'hf);
    // Walk one gate at a time: bit 0 converter up to bit 3 charge timer
    for (int i = 0; i < 4; i++) begin
      b = 4'h1 << i;
      wr(4'h0, 32'h1 << i, 4'hf);
      chk("wr resp", resp, 2'b00);
      chk("clk_en", clk_en, {28'h0, ~b});
      chk("pwr_en", pwr_en, {28'h0, ~b});
      chk("access_en", acc_en, {28'h0, ~b});
      rd(4'h0);
      chk("gate rd", rd_v, {28'h0, b});
      rd(4'h4);
      chk("status rd", rd_v, {28'h0, ~b});
      rst_seen = 4'h0;
      wr(4'h0, 32'h0, 4'hf);
      rd(4'h0);
      chk("regs_rst", rst_seen, b);
      chk("clk_en clr", clk_en, 4'hf);
      chk("access clr", acc_en, 4'hf);
    end
    wr(4'h0, 32'hffff_fff0, 4'hf);
    rd(4'h0);
    chk("upper only", rd_v, 32'h0);
    chk("upper clk_en", clk_en, 4'hf);
    wr(4'h0, 32'hffff_ffff, 4'hf);
    rd(4'h0);
    chk("all set", rd_v, 32'h0000_000f);
    chk("all pwr_en", pwr_en, 4'h0);
    // Byte lane 0 disabled: register must keep its value
    wr(4'h0, 32'h0, 4'he);
    rd(4'h0);
    chk("no strobe", rd_v, 32'h0000_000f);
    rst_seen = 4'h0;
    wr(4'h0, 32'h0, 4'hf);
    rd(4'h0);
    chk("regs_rst all", rst_seen, 4'hf);
    wr(4'h8, 32'h1, 4'hf);
    chk("unmapped wr", resp, 2'b10);
    chk("unmapped noeff", clk_en, 4'hf);
    rd(4'h8);
    chk("unmapped rresp", resp, 2'b10);
    chk("unmapped data", rd_v, 32'h0);
    // Mid-run reset must drop every gate
    wr(4'h0, 32'h9, 4'hf);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(4'h0);
    chk("gate after srst", rd_v, 32'h0);
    chk("clk_en after srst", clk_en, 4'hf);
    results();
  end
endmodule : tb_top
